// ===== rtl/rlc_pkg.sv
// package: register map, field layout, timing and carriers for level control
package rlc_pkg;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned NUM_CFG = 9;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_EN = 8'h30;
  localparam logic [7:0] IDX_RATES = 8'h31;
  localparam logic [7:0] IDX_HOLD = 8'h32;
  localparam logic [7:0] IDX_NOISE = 8'h33;
  localparam logic [7:0] IDX_TGT_LO = 8'h34;
  localparam logic [7:0] IDX_TGT_HI = 8'h35;
  localparam logic [7:0] IDX_GAIN_BND = 8'h36;
  localparam logic [7:0] IDX_ANA_BND = 8'h37;
  localparam logic [7:0] IDX_CLIP = 8'h38;
  localparam logic [7:0] IDX_GAIN_STAT = 8'h39;
  localparam logic [7:0] IDX_STATE_STAT = 8'h3a;
  // reset values and writable bits, indexed from IDX_CHAN_EN
  localparam logic [7:0] CFG_RST [NUM_CFG] =
    '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h3f, 8'h00, 8'hff, 8'h71, 8'h00};
  localparam logic [7:0] CFG_MASK [NUM_CFG] =
    '{8'hff, 8'hff, 8'h0f, 8'h3f, 8'h3f, 8'h3f, 8'hff, 8'h77, 8'h83};
  // field positions
  localparam int unsigned EN_LSB = 0;
  localparam int unsigned HYB_LSB = 4;
  localparam int unsigned ATK_LSB = 0;
  localparam int unsigned REL_LSB = 4;
  localparam int unsigned HOLD_LSB = 0;
  localparam int unsigned LVL_LSB = 0;
  localparam int unsigned ATN_LSB = 0;
  localparam int unsigned GMAX_LSB = 4;
  localparam int unsigned AMIN_LSB = 0;
  localparam int unsigned AMAX_LSB = 4;
  localparam int unsigned CSTEP_LSB = 0;
  localparam int unsigned CEN_BIT = 7;
  // timing, in sample periods; one gain step is 1.5 dB
  localparam int unsigned STEP_MDB = 1500;
  localparam int unsigned REL_CSMP_PER_DB = 2866;
  localparam int unsigned ATK_CSMP_PER_DB = 733;
  localparam int unsigned REL_STEP_SMP =
    (REL_CSMP_PER_DB * STEP_MDB + 99999) / 100000;
  localparam int unsigned ATK_STEP_SMP =
    (ATK_CSMP_PER_DB * STEP_MDB + 99999) / 100000;
  localparam int unsigned HOLD_BASE_SMP = 62;
  localparam int unsigned CLIP_MDB_PER_SMP = 34;
  localparam logic [3:0] REL_CODE_TOP = 4'ha;
  localparam logic [3:0] ATK_CODE_TOP = 4'hc;
  localparam int unsigned CNT_W = 22;
  localparam int unsigned STEPS_PER_6DB = 4;
  localparam logic [2:0] ANA_ZERO_CODE = 3'h1;
  localparam logic [2:0] ANA_TOP_CODE = 3'h5;
  localparam logic [5:0] LVL_FLOOR = 6'h3f;

  typedef enum logic [2:0] {
    ST_OFF, ST_STEADY, ST_ATTACK, ST_HOLD, ST_RELEASE
  } rlc_state_e;

  typedef struct packed {
    logic [3:0] chan_en;
    logic [3:0] hybrid;
    logic [3:0] rel_code;
    logic [3:0] atk_code;
    logic [3:0] hold_code;
    logic [5:0] noise;
    logic [5:0] tgt_lo;
    logic [5:0] tgt_hi;
    logic [3:0] gain_max;
    logic [3:0] atten_max;
    logic [2:0] ana_max;
    logic [2:0] ana_min;
    logic clip_en;
    logic [1:0] clip_step;
  } rlc_cfg_s;

  typedef struct packed {
    logic signed [7:0] dig;
    logic [2:0] ana;
  } rlc_gain_s;
endpackage

// ===== rtl/rlc_level_meter.sv
// sample magnitude to level code, 1.5 dB per code below full scale
`timescale 1ns/1ns
module rlc_level_meter
  import rlc_pkg::*;
#(
  parameter int unsigned SMP_W = 24
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // sample in
  input wire logic valid_in,
  input wire logic [SMP_W-1:0] sample_in,
  // level out
  output logic level_valid_out,
  output logic [5:0] level_out
);
  if (SMP_W < 8 || SMP_W > 32)
  begin : g_bad_width
    $error("rlc_level_meter: SMP_W out of range");
  end

  logic [SMP_W-1:0] mag;
  logic [5:0] code;
  logic valid_ff;
  logic [5:0] level_ff;
  int lz;
  int top;
  int raw;

  // most negative sample saturates instead of wrapping
  assign mag = sample_in[SMP_W-1] ?
    ((sample_in == {1'b1, {(SMP_W-1){1'b0}}}) ?
      {1'b0, {(SMP_W-1){1'b1}}} : (~sample_in + 1'b1)) : sample_in;

  always_comb
  begin
    top = -1;
    for (int i = 0; i < SMP_W - 1; i++)
      if (mag[i])
        top = i;
    lz = SMP_W - 2 - top;
    if (top < 2)
      raw = 63;
    else
      raw = lz * 4 + 4 - int'(mag[top-1 -: 2]);
    code = (raw > 63) ? LVL_FLOOR : 6'(raw);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      valid_ff <= 1'b0;
      level_ff <= LVL_FLOOR;
    end
    else
    begin
      valid_ff <= valid_in;
      if (valid_in)
        level_ff <= code;
    end
  end

  assign level_valid_out = valid_ff;
  assign level_out = level_ff;
endmodule

// ===== rtl/rlc_gain_split.sv
// splits total gain between analog 6 dB steps and digital remainder
`timescale 1ns/1ns
module rlc_gain_split
  import rlc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic hybrid_in,
  input wire logic signed [7:0] gain_in,
  input wire logic [2:0] ana_min_in,
  input wire logic [2:0] ana_max_in,
  // split gain
  output rlc_gain_s gain_out
);
  logic [2:0] eff_min;
  logic [2:0] eff_max;
  logic signed [7:0] g6;
  logic signed [7:0] lo6;
  logic signed [7:0] hi6;
  logic signed [7:0] a6;
  rlc_gain_s nxt_gain;
  rlc_gain_s gain_ff;

  // reserved codes fall back: max code 0 or above ANA_TOP_CODE to ANA_TOP_CODE, min code 0 to ANA_ZERO_CODE
  assign eff_max = (ana_max_in == 3'h0 || ana_max_in > ANA_TOP_CODE) ?
    ANA_TOP_CODE : ana_max_in;
  assign eff_min = (ana_min_in == 3'h0) ? ANA_ZERO_CODE :
    ((ana_min_in > eff_max) ? eff_max : ana_min_in);
  assign g6 = gain_in >>> 2;
  assign lo6 = 8'(eff_min - ANA_ZERO_CODE);
  assign hi6 = 8'(eff_max - ANA_ZERO_CODE);
  assign a6 = (g6 < lo6) ? lo6 : ((g6 > hi6) ? hi6 : g6);

  always_comb
  begin
    if (hybrid_in)
    begin
      nxt_gain.ana = 3'(a6) + ANA_ZERO_CODE;
      nxt_gain.dig = gain_in - 8'(a6 * 4);
    end
    else
    begin
      nxt_gain.ana = ANA_ZERO_CODE;
      nxt_gain.dig = gain_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      gain_ff <= '{dig: 8'h00, ana: ANA_ZERO_CODE};
    else
      gain_ff <= nxt_gain;
  end

  assign gain_out = gain_ff;
endmodule

// ===== rtl/rlc_core.sv
// record level control: register file, per-channel gain loop
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
module rlc_core
  import rlc_pkg::*;
#(
  parameter int unsigned SMP_W = 24,
  parameter int unsigned REL_STEP = REL_STEP_SMP,
  parameter int unsigned ATK_STEP = ATK_STEP_SMP,
  parameter int unsigned HOLD_BASE = HOLD_BASE_SMP
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // adc samples, two channels per adc
  input wire logic [1:0] smp_valid_in,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] smp_data_in,
  // gain to the record path
  output rlc_gain_s [NUM_CH-1:0] gain_out
);
  // refuse settings the counters or the meter cannot hold
  if (REL_STEP < 1 || ATK_STEP < 1 || HOLD_BASE < 1)
  begin : g_bad_step
    $error("rlc_core: timing steps must be at least one sample");
  end
  if ((HOLD_BASE << 15) >= (1 << CNT_W))
  begin : g_bad_hold
    $error("rlc_core: HOLD_BASE too large for counter");
  end
  if ((REL_STEP << 10) >= (1 << CNT_W))
  begin : g_bad_rel
    $error("rlc_core: REL_STEP too large for counter");
  end
  if ((ATK_STEP << 12) >= (1 << CNT_W))
  begin : g_bad_atk
    $error("rlc_core: ATK_STEP too large for counter");
  end
  if (SMP_W < 8 || SMP_W > 32)
  begin : g_bad_width
    $error("rlc_core: SMP_W out of range");
  end
  // register file and index map must agree
  if (NUM_CFG != int'(IDX_CLIP - IDX_CHAN_EN) + 1)
  begin : g_bad_map
    $error("rlc_core: NUM_CFG does not match the register map");
  end

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  logic [7:0] cfg_ff [NUM_CFG];
  logic ack_ff;
  logic [31:0] rd_ff;
  logic [7:0] idx;
  logic req;
  logic wr_lane0;
  logic in_cfg;
  logic [7:0] cfg_off;
  logic [31:0] rd_word;
  logic [31:0] gain_word;
  logic [31:0] state_word;
  rlc_cfg_s cfg;
  rlc_state_e [NUM_CH-1:0] state_mon;
  logic signed [NUM_CH-1:0][7:0] gain_mon;

  assign idx = {2'b00, wb_adr_in[ADR_W-1:2]};
  // ack drops the cycle after it was given, so one request one ack
  assign req = wb_cyc_in & wb_stb_in & ~ack_ff;
  // registers are one byte wide, so only lane 0 writes
  assign wr_lane0 = req & wb_we_in & wb_sel_in[0];
  // status words sit above the writable block and stay read-only
  assign in_cfg = (idx >= IDX_CHAN_EN) && (idx <= IDX_CLIP);
  assign cfg_off = idx - IDX_CHAN_EN;

  generate
    for (genvar r = 0; r < NUM_CFG; r++)
    begin : g_cfg
      logic hit;
      assign hit = wr_lane0 && (cfg_off == 8'(r)) && in_cfg;
      always_ff @(posedge core_clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          cfg_ff[r] <= CFG_RST[r];
        else if (hit)
          cfg_ff[r] <= wb_dat_in[7:0] & CFG_MASK[r];
      end
    end
  endgenerate

  // status packs one byte per channel, channel 0 lowest
  assign gain_word = {gain_mon[3], gain_mon[2], gain_mon[1], gain_mon[0]};

  generate
    for (genvar s = 0; s < NUM_CH; s++)
    begin : g_stat
      assign state_word[s*8 +: 8] = {5'h00, state_mon[s]};
    end
  endgenerate

  // unmapped words answer with zero and ignore writes
  assign rd_word = in_cfg ? {24'h000000, cfg_ff[cfg_off[3:0]]} :
    (idx == IDX_GAIN_STAT) ? gain_word :
    (idx == IDX_STATE_STAT) ? state_word : 32'h00000000;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= req;
      if (req && !wb_we_in)
        rd_ff <= rd_word;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rd_ff;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  assign cfg.chan_en = cfg_ff[0][EN_LSB +: 4];
  assign cfg.hybrid = cfg_ff[0][HYB_LSB +: 4];
  assign cfg.rel_code = cfg_ff[1][REL_LSB +: 4];
  assign cfg.atk_code = cfg_ff[1][ATK_LSB +: 4];
  assign cfg.hold_code = cfg_ff[2][HOLD_LSB +: 4];
  assign cfg.noise = cfg_ff[3][LVL_LSB +: 6];
  assign cfg.tgt_lo = cfg_ff[4][LVL_LSB +: 6];
  assign cfg.tgt_hi = cfg_ff[5][LVL_LSB +: 6];
  assign cfg.gain_max = cfg_ff[6][GMAX_LSB +: 4];
  assign cfg.atten_max = cfg_ff[6][ATN_LSB +: 4];
  assign cfg.ana_max = cfg_ff[7][AMAX_LSB +: 3];
  assign cfg.ana_min = cfg_ff[7][AMIN_LSB +: 3];
  assign cfg.clip_en = cfg_ff[8][CEN_BIT];
  assign cfg.clip_step = cfg_ff[8][CSTEP_LSB +: 2];

  // ---------------------------------------------------------------
  // step intervals, shared by all channels
  // ---------------------------------------------------------------
  logic [3:0] rel_sh;
  logic [3:0] atk_sh;
  logic [CNT_W-1:0] rel_int;
  logic [CNT_W-1:0] atk_int;
  logic [CNT_W-1:0] hold_int;
  logic [CNT_W-1:0] clip_int;
  logic [CNT_W-1:0] fall_int;

  // top codes saturate at the slowest rate
  assign rel_sh = (cfg.rel_code > REL_CODE_TOP) ? REL_CODE_TOP :
    cfg.rel_code;
  assign atk_sh = (cfg.atk_code > ATK_CODE_TOP) ? ATK_CODE_TOP :
    cfg.atk_code;
  assign rel_int = CNT_W'(REL_STEP) << rel_sh;
  assign atk_int = CNT_W'(ATK_STEP) << atk_sh;
  assign hold_int = CNT_W'(HOLD_BASE) << cfg.hold_code;
  // 1.5 dB per step at 34 mdB per sample shifted left by clip_step, rounded up
  assign clip_int = CNT_W'((STEP_MDB +
    (CLIP_MDB_PER_SMP << cfg.clip_step) - 1) /
    (CLIP_MDB_PER_SMP << cfg.clip_step));
  // clip guard replaces the attack rate while it is on
  assign fall_int = cfg.clip_en ? clip_int : atk_int;

  // gain range in 1.5 dB steps
  logic signed [7:0] gain_hi;
  logic signed [7:0] gain_lo;
  assign gain_hi = 8'(cfg.gain_max * STEPS_PER_6DB);
  assign gain_lo = -8'(cfg.atten_max * STEPS_PER_6DB);

  // ---------------------------------------------------------------
  // per-channel loop
  // ---------------------------------------------------------------
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic lvl_v;
      logic [5:0] lvl;
      logic en;
      logic hyb;
      logic signed [8:0] out_lvl;
      logic below_floor;
      logic too_loud;
      logic too_quiet;
      logic [CNT_W-1:0] cnt_inc;
      rlc_state_e state_ff;
      rlc_state_e nxt_state;
      logic [CNT_W-1:0] cnt_ff;
      logic [CNT_W-1:0] nxt_cnt;
      logic signed [7:0] gain_ff;
      logic signed [7:0] nxt_gain;
      logic signed [7:0] step_gain;

      // each adc paces its own two channels
      rlc_level_meter #(
        .SMP_W(SMP_W)
      ) u_meter (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .valid_in(smp_valid_in[c/2]),
        .sample_in(smp_data_in[c]),
        .level_valid_out(lvl_v),
        .level_out(lvl)
      );

      assign en = cfg.chan_en[c];
      assign hyb = cfg.hybrid[(c/2)*2];
      // larger code is quieter, so boost lowers the output code
      assign out_lvl = $signed({3'b000, lvl}) - 9'(gain_ff);
      // floor judged on the input, so boost cannot wake noise
      assign below_floor = lvl >= cfg.noise;
      assign too_loud = out_lvl < $signed({3'b000, cfg.tgt_hi});
      assign too_quiet = out_lvl > $signed({3'b000, cfg.tgt_lo});
      // counter sized for the longest hold, so it never wraps
      assign cnt_inc = cnt_ff + 1'b1;

      always_comb
      begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        step_gain = gain_ff;
        if (!en)
        begin
          nxt_state = ST_OFF;
          nxt_cnt = '0;
          step_gain = 8'h00;
        end
        else if (lvl_v && !below_floor)
        begin
          if (too_loud)
          begin
            nxt_state = ST_ATTACK;
            nxt_cnt = (state_ff == ST_ATTACK) ? cnt_inc : CNT_W'(1);
            if (nxt_cnt >= fall_int)
            begin
              nxt_cnt = '0;
              step_gain = gain_ff - 8'sh01;
            end
          end
          else if (too_quiet)
          begin
            case (state_ff)
              ST_RELEASE:
              begin
                nxt_cnt = cnt_inc;
                if (cnt_inc >= rel_int)
                begin
                  nxt_cnt = '0;
                  step_gain = gain_ff + 8'sh01;
                end
              end
              ST_HOLD:
              begin
                nxt_cnt = cnt_inc;
                if (cnt_inc >= hold_int)
                begin
                  nxt_state = ST_RELEASE;
                  nxt_cnt = '0;
                end
              end
              default:
              begin
                nxt_state = ST_HOLD;
                nxt_cnt = CNT_W'(1);
              end
            endcase
          end
          else
          begin
            nxt_state = ST_STEADY;
            nxt_cnt = '0;
          end
        end
        // re-enable starts steady with a clear count
        else if (state_ff == ST_OFF)
        begin
          nxt_state = ST_STEADY;
        end
        // limits may be lowered while running
        if (step_gain > gain_hi)
          nxt_gain = gain_hi;
        else if (step_gain < gain_lo)
          nxt_gain = gain_lo;
        else
          nxt_gain = step_gain;
      end

      always_ff @(posedge core_clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          state_ff <= ST_OFF;
          cnt_ff <= '0;
          gain_ff <= 8'h00;
        end
        else
        begin
          state_ff <= nxt_state;
          cnt_ff <= nxt_cnt;
          gain_ff <= nxt_gain;
        end
      end

      // one more register: gain_out trails the loop by an edge
      rlc_gain_split u_split (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .hybrid_in(hyb),
        .gain_in(gain_ff),
        .ana_min_in(cfg.ana_min),
        .ana_max_in(cfg.ana_max),
        .gain_out(gain_out[c])
      );

      assign state_mon[c] = state_ff;
      assign gain_mon[c] = gain_ff;
    end
  endgenerate
endmodule

// ===== testbench/rlc_chk.sv
// checker: bus timing and channel 0 gain behaviour of the core
`timescale 1ns/1ns
module rlc_chk
  import rlc_pkg::*;
#(
  parameter int unsigned SMP_W = 24
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wishbone
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  // samples and gains
  input wire logic [1:0] smp_valid_in,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] smp_data_in,
  input wire rlc_gain_s [NUM_CH-1:0] gain_out
);
  logic [7:0] en_ff;
  logic [7:0] bnd_ff;
  logic [3:0] ack_age_ff;
  logic [3:0] smp_age_ff;
  logic wr_hit;
  logic signed [7:0] g0;
  logic signed [7:0] g_hi;
  logic signed [7:0] g_lo;
  assign wr_hit = wb_ack_out && wb_we_in && wb_sel_in[0];
  assign g0 = gain_out[0].dig;
  assign g_hi = $signed({2'b00, bnd_ff[7:4], 2'b00});
  assign g_lo = -$signed({2'b00, bnd_ff[3:0], 2'b00});

  // shadows of the config the assertions depend on
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      en_ff <= 8'h00;
      bnd_ff <= 8'hff;
      ack_age_ff <= 4'hf;
      smp_age_ff <= 4'hf;
    end
    else
    begin
      if (wr_hit && wb_adr_in[7:2] == IDX_CHAN_EN[5:0])
        en_ff <= wb_dat_in[7:0];
      if (wr_hit && wb_adr_in[7:2] == IDX_GAIN_BND[5:0])
        bnd_ff <= wb_dat_in[7:0];
      ack_age_ff <= wb_ack_out ? 4'h0 :
        ack_age_ff + {3'b000, ack_age_ff != 4'hf};
      smp_age_ff <= (wb_ack_out || smp_valid_in[0]) ? 4'h0 :
        smp_age_ff + {3'b000, smp_age_ff != 4'hf};
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  ack_pulse_a: assert property (
    wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  ack_timely_a: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered in one cycle");
  off_gain_a: assert property (
    !en_ff[0] && ack_age_ff > 4'h4
    |-> g0 == 8'sh00 && gain_out[0].ana == ANA_ZERO_CODE)
    else $error("disabled channel has gain");
  floor_hold_a: assert property (
    (!smp_valid_in[0] && !wb_ack_out)[*3] ##1
    (smp_valid_in[0] && smp_data_in[0] == '0) ##1
    (!smp_valid_in[0] && !wb_ack_out)[*4]
    |-> gain_out[0] == $past(gain_out[0], 4))
    else $error("gain moved on a sample under the floor");
  gain_quiet_a: assert property (
    smp_age_ff > 4'h4 |-> $stable(gain_out[0]))
    else $error("gain moved without a sample");
  step_size_a: assert property (
    !en_ff[4] && ack_age_ff > 4'h4 && g0 != $past(g0)
    |-> g0 == $past(g0) + 8'sd1 || g0 == $past(g0) - 8'sd1)
    else $error("gain moved by more than one step");
  gain_bounds_a: assert property (
    !en_ff[4] && ack_age_ff > 4'h4 |-> g0 <= g_hi && g0 >= g_lo)
    else $error("gain outside its limits");
  ana_plain_a: assert property (
    !en_ff[4] && ack_age_ff > 4'h4 |-> gain_out[0].ana == ANA_ZERO_CODE)
    else $error("analog gain used outside hybrid mode");
  ana_range_a: assert property (
    gain_out[0].ana >= ANA_ZERO_CODE && gain_out[0].ana <= ANA_TOP_CODE)
    else $error("analog code out of range");
endmodule

// ===== testbench/tb_top.sv
// self-checking bench: register map and gain loop of the core
`timescale 1ns/1ns
module tb_top
  import rlc_pkg::*;
;
  localparam int unsigned RS = 1;
  localparam int unsigned AS = 1;
  localparam int unsigned HB = 2;
  // targets far from reachable levels so only the 6 dB limits stop a ramp
  localparam logic [7:0] SETUP [NUM_CFG] =
    '{8'h0f, 8'h00, 8'h00, 8'h3f, 8'h28, 8'h14, 8'h11, 8'h71, 8'h00};
  logic core_clk_in;
  logic rst_n_in;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [1:0] smp_valid;
  logic [NUM_CH-1:0][23:0] smp_data;
  rlc_gain_s [NUM_CH-1:0] gain;
  logic [31:0] rd;
  logic [7:0] en_m;
  int m_gain [NUM_CH];
  int errors;
  int n_tests;
  int seed;
  int f;

  rlc_core #(.SMP_W(24), .REL_STEP(RS), .ATK_STEP(AS), .HOLD_BASE(HB))
    uut (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb),
    .wb_we_in(wb_we),
    .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack),
    .smp_valid_in(smp_valid),
    .smp_data_in(smp_data),
    .gain_out(gain)
  );

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic final_report;
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic we, input int idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= 8'(idx * 4);
    wb_wdat <= {24'h000000, d};
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      $display("ERROR wishbone ack expected 1 got %b", wb_ack);
    end
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp);
    n_tests++;
    if (rd !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h got %h", what, exp, rd);
    end
  endtask

  // model split: analog takes whole 6 dB steps, never below 0 dB
  task automatic chk_gain(input string what);
    rlc_gain_s e;
    int a;
    for (int c = 0; c < NUM_CH; c++)
    begin
      a = 0;
      if (en_m[4 + (c / 2) * 2] && m_gain[c] > 0)
        a = m_gain[c] / 4;
      e.dig = 8'(m_gain[c] - 4 * a);
      e.ana = 3'(a) + ANA_ZERO_CODE;
      n_tests++;
      if (gain[c] !== e)
      begin
        errors++;
        $display("ERROR %s ch%0d expected %h got %h", what, c, e, gain[c]);
      end
    end
  endtask

  task automatic mstep(input int d);
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (en_m[c])
        m_gain[c] += d;
      if (m_gain[c] > int'(STEPS_PER_6DB))
        m_gain[c] = STEPS_PER_6DB;
      if (m_gain[c] < -int'(STEPS_PER_6DB))
        m_gain[c] = -int'(STEPS_PER_6DB);
    end
  endtask

  // disabling first clears every gain, so each case starts at 0 dB
  task automatic restart(input logic [7:0] v);
    xfer(1'b1, IDX_CHAN_EN, 8'h00);
    xfer(1'b1, IDX_CHAN_EN, v);
    en_m = v;
    for (int c = 0; c < NUM_CH; c++)
      m_gain[c] = 0;
  endtask

  // kind 0 loud, 1 quiet (above floor), other zero
  task automatic feed(input int n, input int kind);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk_in);
      smp_valid <= 2'b11;
      for (int c = 0; c < NUM_CH; c++)
        case (kind)
          0: smp_data[c] <= {2'b01, 22'($random(seed))};
          1: smp_data[c] <= {13'h0000, 1'b1, 10'($random(seed))};
          default: smp_data[c] <= 24'h000000;
        endcase
    end
    @(posedge core_clk_in);
    smp_valid <= 2'b00;
    repeat (6) @(posedge core_clk_in);
  endtask

  initial
  begin
    repeat (80000) @(posedge core_clk_in);
    errors++;
    final_report;
  end

  initial
  begin
    seed = 89816;
    errors = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h1;
    wb_wdat = 32'h00000000;
    smp_valid = 2'b00;
    smp_data = '0;
    en_m = 8'h00;
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < NUM_CFG; i++)
    begin
      xfer(1'b0, IDX_CHAN_EN + i, 8'h00);
      chk_reg("reset value", {24'h000000, CFG_RST[i]});
      xfer(1'b1, IDX_CHAN_EN + i, 8'hff);
      xfer(1'b0, IDX_CHAN_EN + i, 8'h00);
      chk_reg("write mask", {24'h000000, CFG_MASK[i]});
    end
    xfer(1'b1, IDX_GAIN_STAT, 8'hff);
    xfer(1'b0, IDX_GAIN_STAT, 8'h00);
    chk_reg("gain status", 32'h00000000);
    xfer(1'b1, 8'h3f, 8'hff);
    xfer(1'b0, 8'h3f, 8'h00);
    chk_reg("unmapped", 32'h00000000);
    for (int i = 1; i < NUM_CFG; i++)
      xfer(1'b1, IDX_CHAN_EN + i, SETUP[i]);
    for (int k = 0; k < 16; k++)
    begin
      xfer(1'b1, IDX_RATES, 8'(k));
      restart(8'h0f);
      f = AS << (k > 12 ? 12 : k);
      feed(f + f / 2, 0);
      mstep(-1);
      chk_gain("attack");
    end
    for (int k = 0; k < 16; k++)
    begin
      xfer(1'b1, IDX_RATES, 8'(k << 4));
      restart(8'h0f);
      f = RS << (k > 10 ? 10 : k);
      feed(HB + f + f / 2, 1);
      mstep(1);
      chk_gain("release");
    end
    xfer(1'b1, IDX_RATES, 8'h00);
    for (int k = 0; k < 12; k++)
    begin
      xfer(1'b1, IDX_HOLD, 8'(k));
      restart(8'h0f);
      feed((HB << k) - 1, 1);
      chk_gain("hold");
      feed(2, 1);
      mstep(1);
      chk_gain("hold end");
    end
    xfer(1'b1, IDX_HOLD, 8'h00);
    xfer(1'b1, IDX_RATES, 8'h0f);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, IDX_CLIP, 8'(8'h80 | k));
      restart(8'h0f);
      f = (STEP_MDB + (CLIP_MDB_PER_SMP << k) - 1) / (CLIP_MDB_PER_SMP << k);
      feed(f + f / 2, 0);
      mstep(-1);
      chk_gain("clip guard");
    end
    xfer(1'b1, IDX_CLIP, 8'h00);
    xfer(1'b1, IDX_RATES, 8'h00);
    xfer(1'b1, IDX_NOISE, 8'h20);
    restart(8'h0f);
    feed(40, 1);
    feed(1, 2);
    chk_gain("noise floor");
    xfer(1'b1, IDX_NOISE, 8'h3f);
    restart(8'h1f);
    feed(20, 1);
    mstep(8);
    chk_gain("hybrid boost");
    feed(20, 0);
    mstep(-8);
    chk_gain("hybrid cut");
    restart(8'h05);
    feed(20, 0);
    mstep(-8);
    chk_gain("partial enable");
    xfer(1'b0, IDX_STATE_STAT, 8'h00);
    chk_reg("channel states", 32'h00020002);
    xfer(1'b0, IDX_GAIN_STAT, 8'h00);
    chk_reg("gain words", 32'h00fc00fc);
    final_report;
  end
endmodule

bind rlc_core rlc_chk #(.SMP_W(SMP_W)) chk (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in),
  .wb_ack_out(wb_ack_out),
  .smp_valid_in(smp_valid_in),
  .smp_data_in(smp_data_in),
  .gain_out(gain_out)
);
